// ==== include/crirq_pkg.sv ====
package crirq_pkg;
	// register offsets (printed values are indices, not byte addresses: byte address = 4*index)
	localparam logic [15:0] IDX_STATUS  = 16'hfe01;
	localparam logic [15:0] IDX_ENABLE  = 16'hfe02;
	localparam logic [15:0] IDX_SUPPLY  = 16'hfe03;
	localparam logic [15:0] IDX_SELECT  = 16'hfe00;
	localparam logic [15:0] IDX_MODE    = 16'hfe10;
	localparam logic [7:0]  RST_STATUS  = 8'h00;
	localparam logic [7:0]  RST_ENABLE  = 8'h00;
	localparam logic [7:0]  RST_SUPPLY  = 8'h00;
	localparam logic [7:0]  RST_SELECT  = 8'h00;
	localparam logic [7:0]  RST_MODE    = 8'h00;
	// status / enable bit positions
	localparam int B_WAIT  = 7;
	localparam int B_CARD  = 6;
	localparam int B_VTMR  = 5;
	localparam int B_RX_AVAILABLE_FLAG = 4;
	localparam int B_TXEV  = 3;
	localparam int B_TXDN  = 2;
	localparam int B_TXER  = 1;
	localparam int B_RXER  = 0;
	// supply control positions
	localparam int B_SEL_HI = 7;
	localparam int B_SEL_LO = 6;
	localparam int B_VFLT   = 5;
	localparam int B_POWER_DOWN_BIT  = 0;
	// select register positions
	localparam int B_IFSEL_HI = 3;
	localparam int B_IFSEL_LO = 2;
	localparam int B_BYPASS   = 1;
	// mode register positions
	localparam int B_SYNC     = 0;
	localparam int B_CLKSTOP  = 1;
	localparam int B_BLOCKP   = 2;
	localparam int B_BRKEN    = 3;
	localparam int B_FLT_EN   = 4;

	// per-interface event inputs from the card uart side
	typedef struct packed {
		logic atr_timeout;
		logic wait_timeout;
		logic bit_count_max;
		logic bit_count_terminal;
		logic tx_fifo_empty;
		logic tx_fifo_full;
		logic byte_sent;
		logic check_byte_sent;
		logic byte_break;
		logic break_detected;
		logic tx_underrun;
		logic rx_overrun;
		logic rx_parity_error;
		logic rx_fifo_nonempty;
	} crirq_events_type;

	// read strobes of registers held elsewhere
	typedef struct packed {
		logic tx_ctl_read;
		logic rx_ctl_read;
	} crirq_reads_type;
endpackage

// ==== src/crirq_top.sv ====
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R1: status read clears read-clearable bits; reset zero
// R2: status follows selected card interface
// R3: async: timeout sets wait bit
// R4: sync: bit counter maximum sets wait bit
// R5: clock-stop sync: terminal count sets wait bit
// R6: card detect change or fault sets event
// R7: card event works with clock off; here detect sampling and status update stall while clk_en is low
// R8: supply timer expiry sets supply bit
// R9: rx available follows fifo non-empty
// R10: bypass: io falling edge sets rx available
// R11: firmware masks rx available during bypass byte
// R12: tx flags set event; tx control read clears
// R13: byte or check byte sent sets done
// R14: char mode break byte sets no done
// R15: break or underrun sets error; tx read clears
// R16: overrun or parity sets rx error; rx read clears
// R17: enable gates interrupt, not status
// R18: sync: wait enable gates bit count irq
// R19: firmware writes both supply selects together
// R20: enabled core fault forces internal deactivation
// R21: supply not good at interval end: deactivate
// R22: bypass routes io via control registers
// R23: irq while status and enable both set
module crirq_top (
	// apb
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          clk_en,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// events of external and internal interfaces
	input  wire crirq_pkg::crirq_events_type   ext_events,
	input  wire crirq_pkg::crirq_events_type   int_events,
	input  wire crirq_pkg::crirq_reads_type    reg_reads,
	// pins
	input  wire logic                          card_detect_input,
	input  wire logic                          card_io_in,
	input  wire logic                          core_supply_fault,
	input  wire logic                          supply_good,
	input  wire logic                          supply_stable_timer,
	// outputs
	output logic                               card_irq,
	output logic                               card_deactivate,
	output logic                               card_io_bypass_out,
	output logic [1:0]                         supply_select,
	output logic [1:0]                         card_interface_select
);
	typedef enum logic [1:0] {
		CRIRQ_IDLE   = 2'b01,
		CRIRQ_ACCESS = 2'b10
	} crirq_state_type;

	function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
		hit = (a[31:2] == {14'h0000, idx});
	endfunction

	// pin synchronisers and edge history
	logic [1:0]                  det_s_q;
	logic [1:0]                  det_s_d;
	logic [1:0]                  io_s_q;
	logic [1:0]                  io_s_d;
	logic [1:0]                  flt_s_q;
	logic [1:0]                  flt_s_d;
	logic [1:0]                  good_s_q;
	logic [1:0]                  good_s_d;
	logic [1:0]                  tmr_s_q;
	logic [1:0]                  tmr_s_d;
	logic                        det_p_q;
	logic                        det_p_d;
	logic                        io_p_q;
	logic                        io_p_d;
	logic                        tmr_p_q;
	logic                        tmr_p_d;
	// bus state
	crirq_state_type             st_q;
	crirq_state_type             st_d;
	logic [31:0]                 rdata_q;
	logic [31:0]                 rdata_d;
	logic                        ready_q;
	logic                        ready_d;
	logic                        err_q;
	logic                        err_d;
	// registers and outputs
	logic [7:0]                  stat_q;
	logic [7:0]                  stat_d;
	logic [7:0]                  en_q;
	logic [7:0]                  en_d;
	logic [7:0]                  sup_q;
	logic [7:0]                  sup_d;
	logic [7:0]                  sel_q;
	logic [7:0]                  sel_d;
	logic [7:0]                  mode_q;
	logic [7:0]                  mode_d;
	logic                        irq_q;
	logic                        irq_d;
	logic                        deact_q;
	logic                        deact_d;
	logic                        bio_q;
	logic                        bio_d;
	// decoded strobes and events
	crirq_pkg::crirq_events_type ev;
	logic                        bypass;
	logic                        sync_m;
	logic                        setup;
	logic                        acc_ph;
	logic                        wr;
	logic                        rd;
	logic                        mapped;
	logic                        hit_st;
	logic                        hit_en;
	logic                        hit_sup;
	logic                        hit_sel;
	logic                        hit_mode;
	logic                        det_edge;
	logic                        io_fall;
	logic                        tmr_rise;
	logic                        wait_set;
	logic                        done_set;
	logic                        status_read;

	assign bypass      = sel_q[crirq_pkg::B_BYPASS];
	assign sync_m      = mode_q[crirq_pkg::B_SYNC];
	assign setup       = psel && !penable && st_q == CRIRQ_IDLE;
	// R1: writes land at the access edge
	assign acc_ph      = psel && penable && st_q == CRIRQ_ACCESS;
	assign hit_st      = hit(paddr, crirq_pkg::IDX_STATUS);
	assign hit_en      = hit(paddr, crirq_pkg::IDX_ENABLE);
	assign hit_sup     = hit(paddr, crirq_pkg::IDX_SUPPLY);
	assign hit_sel     = hit(paddr, crirq_pkg::IDX_SELECT);
	assign hit_mode    = hit(paddr, crirq_pkg::IDX_MODE);
	assign mapped      = hit_st || hit_en || hit_sup || hit_sel || hit_mode;
	assign wr          = acc_ph && pwrite && pstrb[0] && mapped;
	assign rd          = setup && !pwrite;
	assign status_read = rd && hit_st;

	always_comb begin
		// R2: events of selected interface
		if (sel_q[crirq_pkg::B_IFSEL_HI])
			ev = int_events;
		else if (sel_q[crirq_pkg::B_IFSEL_LO])
			ev = ext_events;
		else
			ev = '0;
	end

	always_comb begin
		det_s_d  = {det_s_q[0], card_detect_input};
		io_s_d   = {io_s_q[0], card_io_in};
		flt_s_d  = {flt_s_q[0], core_supply_fault};
		good_s_d = {good_s_q[0], supply_good};
		tmr_s_d  = {tmr_s_q[0], supply_stable_timer};
		det_p_d  = det_s_q[1];
		io_p_d   = io_s_q[1];
		tmr_p_d  = tmr_s_q[1];
		// R6: detect change on either edge
		det_edge = det_s_q[1] ^ det_p_q;
		io_fall  = io_p_q && !io_s_q[1];
		tmr_rise = tmr_s_q[1] && !tmr_p_q;
	end

	always_comb begin
		// R3: async timeouts
		wait_set = !sync_m && (ev.atr_timeout || ev.wait_timeout);
		// R5: clock-stop terminal count
		if (sync_m && mode_q[crirq_pkg::B_CLKSTOP])
			wait_set = ev.bit_count_terminal;
		// R4: sync counter maximum
		else if (sync_m)
			wait_set = ev.bit_count_max;
		// R13: byte or check byte sent
		done_set = ev.byte_sent || (mode_q[crirq_pkg::B_BLOCKP] && ev.check_byte_sent);
		// R14: break suppresses done
		if (!mode_q[crirq_pkg::B_BLOCKP] && mode_q[crirq_pkg::B_BRKEN] && ev.byte_break)
			done_set = 1'b0;

		stat_d = stat_q;
		// R1: read clears, set wins
		if (status_read) begin
			stat_d[crirq_pkg::B_WAIT] = 1'b0;
			stat_d[crirq_pkg::B_CARD] = 1'b0;
			stat_d[crirq_pkg::B_VTMR] = 1'b0;
			stat_d[crirq_pkg::B_TXDN] = 1'b0;
		end
		if (reg_reads.tx_ctl_read) begin
			stat_d[crirq_pkg::B_TXEV] = 1'b0;
			stat_d[crirq_pkg::B_TXER] = 1'b0;
		end
		// R16: rx control read clears
		if (reg_reads.rx_ctl_read)
			stat_d[crirq_pkg::B_RXER] = 1'b0;
		if (wait_set)
			stat_d[crirq_pkg::B_WAIT] = 1'b1;
		// R7: pin path is also gated by clk_en
		if (det_edge)
			stat_d[crirq_pkg::B_CARD] = 1'b1;
		// R8: supply timer expiry
		if (tmr_rise)
			stat_d[crirq_pkg::B_VTMR] = 1'b1;
		// R12: tx fifo flags
		if (ev.tx_fifo_empty || ev.tx_fifo_full)
			stat_d[crirq_pkg::B_TXEV] = 1'b1;
		if (done_set)
			stat_d[crirq_pkg::B_TXDN] = 1'b1;
		// R15: break or underrun
		if (ev.break_detected || ev.tx_underrun)
			stat_d[crirq_pkg::B_TXER] = 1'b1;
		// R16: overrun or parity
		if (ev.rx_overrun || ev.rx_parity_error)
			stat_d[crirq_pkg::B_RXER] = 1'b1;
		// R10: bypass io falling edge
		if (bypass) begin
			if (io_fall)
				stat_d[crirq_pkg::B_RX_AVAILABLE_FLAG] = 1'b1;
			else if (status_read)
				stat_d[crirq_pkg::B_RX_AVAILABLE_FLAG] = 1'b0;
		end else begin
			// R9: follows fifo level
			stat_d[crirq_pkg::B_RX_AVAILABLE_FLAG] = ev.rx_fifo_nonempty;
		end

		en_d   = en_q;
		sel_d  = sel_q;
		mode_d = mode_q;
		sup_d  = sup_q;
		if (wr && hit(paddr, crirq_pkg::IDX_ENABLE))
			en_d = pwdata[7:0];
		if (wr && hit(paddr, crirq_pkg::IDX_SELECT))
			sel_d = pwdata[7:0] & 8'h0f;
		if (wr && hit(paddr, crirq_pkg::IDX_MODE))
			mode_d = pwdata[7:0] & 8'h1f;
		// R19: one write sets both selects
		if (wr && hit(paddr, crirq_pkg::IDX_SUPPLY))
			sup_d = {pwdata[7:6], sup_q[5], 4'h0, pwdata[0]};
		deact_d = 1'b0;
		// R20: core fault emergency deactivation
		if (mode_q[crirq_pkg::B_FLT_EN] && flt_s_q[1]) begin
			sup_d[crirq_pkg::B_VFLT]   = 1'b1;
			sup_d[crirq_pkg::B_SEL_HI] = 1'b0;
			sup_d[crirq_pkg::B_SEL_LO] = 1'b0;
			deact_d = sel_q[crirq_pkg::B_IFSEL_HI];
		end
		// R21: supply not good at interval end
		if (tmr_rise && !good_s_q[1]) begin
			stat_d[crirq_pkg::B_CARD]  = 1'b1;
			sup_d[crirq_pkg::B_SEL_HI] = 1'b0;
			sup_d[crirq_pkg::B_SEL_LO] = 1'b0;
			deact_d = 1'b1;
		end
	end

	// R22: bypass io driven from select register
	always_comb begin
		bio_d = bypass ? sel_q[0] : 1'b1;
	end

	// R17: enable gates only the request
	// R18: wait enable covers sync counter
	// R23: any enabled status raises irq
	always_comb begin
		irq_d = |(stat_q & en_q);
	end

	always_comb begin
		st_d    = st_q;
		ready_d = 1'b0;
		err_d   = 1'b0;
		rdata_d = rdata_q;
		case (st_q)
			CRIRQ_IDLE: begin
				if (setup) begin
					st_d    = CRIRQ_ACCESS;
					ready_d = 1'b1;
					err_d   = !mapped;
					rdata_d = 32'h0000_0000;
					if (rd && hit(paddr, crirq_pkg::IDX_STATUS))
						rdata_d = {24'h00_0000, stat_q};
					else if (rd && hit(paddr, crirq_pkg::IDX_ENABLE))
						rdata_d = {24'h00_0000, en_q};
					else if (rd && hit(paddr, crirq_pkg::IDX_SUPPLY))
						rdata_d = {24'h00_0000, sup_q[7:5], 1'b0, good_s_q[1], 2'b00, sup_q[0]};
					else if (rd && hit(paddr, crirq_pkg::IDX_SELECT))
						rdata_d = {24'h00_0000, sel_q};
					else if (rd && hit(paddr, crirq_pkg::IDX_MODE))
						rdata_d = {24'h00_0000, mode_q};
				end
			end
			CRIRQ_ACCESS: begin
				st_d = CRIRQ_IDLE;
			end
			default: begin
				st_d = CRIRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_s_q  <= 2'b00;
			io_s_q   <= 2'b11;
			flt_s_q  <= 2'b00;
			good_s_q <= 2'b00;
			tmr_s_q  <= 2'b00;
			det_p_q  <= 1'b0;
			io_p_q   <= 1'b1;
			tmr_p_q  <= 1'b0;
		end else if (clk_en) begin
			det_s_q  <= det_s_d;
			io_s_q   <= io_s_d;
			flt_s_q  <= flt_s_d;
			good_s_q <= good_s_d;
			tmr_s_q  <= tmr_s_d;
			det_p_q  <= det_p_d;
			io_p_q   <= io_p_d;
			tmr_p_q  <= tmr_p_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q   <= crirq_pkg::RST_STATUS;
			en_q     <= crirq_pkg::RST_ENABLE;
			sup_q    <= crirq_pkg::RST_SUPPLY;
			sel_q    <= crirq_pkg::RST_SELECT;
			mode_q   <= crirq_pkg::RST_MODE;
		end else if (clk_en) begin
			stat_q   <= stat_d;
			en_q     <= en_d;
			sup_q    <= sup_d;
			sel_q    <= sel_d;
			mode_q   <= mode_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q    <= 1'b0;
			deact_q  <= 1'b0;
			bio_q    <= 1'b1;
		end else if (clk_en) begin
			irq_q    <= irq_d;
			deact_q  <= deact_d;
			bio_q    <= bio_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= CRIRQ_IDLE;
			rdata_q  <= 32'h0000_0000;
			ready_q  <= 1'b0;
			err_q    <= 1'b0;
		end else if (clk_en) begin
			st_q     <= st_d;
			rdata_q  <= rdata_d;
			ready_q  <= ready_d;
			err_q    <= err_d;
		end
	end

	assign prdata                = rdata_q;
	assign pready                = ready_q;
	assign pslverr               = err_q;
	assign card_irq              = irq_q;
	assign card_deactivate       = deact_q;
	assign card_io_bypass_out    = bio_q;
	assign supply_select         = sup_q[7:6];
	assign card_interface_select = sel_q[3:2];
endmodule

// ==== tb/crirq_assertions.sv ====
`timescale 1ns/1ps
module crirq_assertions (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// outputs
	input wire logic        card_irq,
	input wire logic        card_deactivate,
	input wire logic [1:0]  supply_select,
	input wire logic [1:0]  card_interface_select
);
	logic       wr;
	logic [7:0] en_d;
	logic [7:0] en_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel && penable && pwrite && pstrb[0] && pready;
	always_comb begin
		en_d = en_q;
		if (wr && paddr == 32'h0003_f808) en_d = pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) en_q <= 8'h00;
		else en_q <= en_d;
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_iface_write: assert property (wr && paddr == 32'h0003_f800 |=>
		card_interface_select == $past(pwdata[3:2]))
		else $error("interface select not written");
	a_iface_hold: assert property (!wr |=> $stable(card_interface_select))
		else $error("interface select moved");
	a_supply_write: assert property (wr && paddr == 32'h0003_f80c |=>
		supply_select == $past(pwdata[7:6]))
		else $error("supply select not written");
	a_irq_masked: assert property ((en_q == 8'h00) [*2] |-> !card_irq)
		else $error("interrupt with all enables off");
	a_deact_clears: assert property (card_deactivate |-> ##[0:2] supply_select == 2'b00)
		else $error("deactivation kept supply select");
	c_irq: cover property ($rose(card_irq));
	c_deact: cover property (card_deactivate);
	c_refused: cover property (pready && pslverr);
endmodule
bind crirq_top crirq_assertions i_crirq_assertions (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.card_irq(card_irq), .card_deactivate(card_deactivate),
	.supply_select(supply_select), .card_interface_select(card_interface_select));

// ==== tb/crirq_test.sv ====
`timescale 1ns/1ps
module crirq_test;
	localparam logic [31:0] A_SEL = 32'h0003_f800;
	localparam logic [31:0] A_ST = 32'h0003_f804;
	localparam logic [31:0] A_EN = 32'h0003_f808;
	localparam logic [31:0] A_SUP = 32'h0003_f80c;
	localparam logic [31:0] A_MOD = 32'h0003_f840;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd, t;
	logic [3:0] pstrb;
	logic card_irq, card_deactivate, card_io_bypass_out;
	logic [1:0] supply_select, card_interface_select;
	crirq_pkg::crirq_events_type ext_events, int_events;
	crirq_pkg::crirq_reads_type reg_reads;
	logic card_detect_input, card_io_in, core_supply_fault, supply_good, supply_stable_timer;
	int err_total, samples_checked, i;
	logic deact_seen;
	always @(posedge pclk) begin
		if (card_deactivate === 1'b1)
			deact_seen <= 1'b1;
	end
	// mode, clear kind, event, expected status
	logic [31:0] tab [13] = '{32'h0020_0080, 32'h0010_0080, 32'h0108_0080, 32'h0304_0080,
		32'h0400_4004, 32'h0800_a000, 32'h0000_8004, 32'h0042_0008, 32'h0041_0008,
		32'h0040_1002, 32'h0040_0802, 32'h0080_0401, 32'h0080_0201};
	crirq_top i_crirq_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_events(ext_events),
		.int_events(int_events), .reg_reads(reg_reads), .card_detect_input(card_detect_input),
		.card_io_in(card_io_in), .core_supply_fault(core_supply_fault),
		.supply_good(supply_good), .supply_stable_timer(supply_stable_timer),
		.card_irq(card_irq), .card_deactivate(card_deactivate),
		.card_io_bypass_out(card_io_bypass_out), .supply_select(supply_select),
		.card_interface_select(card_interface_select));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			end_sim();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task automatic ev(input logic x, input logic [13:0] e);
		if (x) ext_events <= crirq_pkg::crirq_events_type'(e);
		else int_events <= crirq_pkg::crirq_events_type'(e);
		@(posedge pclk);
		ext_events <= '0;
		int_events <= '0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic wait6(input logic [31:0] a, input logic [31:0] e);
		repeat (6) @(posedge pclk);
		rdc(a, e);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{card_detect_input, core_supply_fault, supply_good, supply_stable_timer} = '0;
		{ext_events, int_events, reg_reads} = '0;
		pstrb = 4'hf;
		clk_en = 1'b1;
		card_io_in = 1'b1;
		err_total = 0;
		samples_checked = 0;
		deact_seen = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(A_ST, 32'h0000_0000);
		rdc(A_EN, 32'h0000_0000);
		rdc(A_SUP, 32'h0000_0000);
		rdc(A_SEL, 32'h0000_0000);
		rdc(32'h0003_f820, 32'h0000_0000);
		chk(er, 1'b1);
		wr(A_SEL, 8'h08);
		wr(A_EN, 8'hff);
		rdc(A_EN, 32'h0000_00ff);
		for (i = 0; i < 13; i++) begin
			t = tab[i];
			wr(A_MOD, t[31:24]);
			ev(1'b0, t[21:8]);
			chk(card_irq, |t[7:0]);
			rdc(A_ST, {24'h00_0000, t[7:0]});
			rdc(A_ST, (t[23:22] == 2'b00) ? 32'h0000_0000 : {24'h00_0000, t[7:0]});
			reg_reads <= crirq_pkg::crirq_reads_type'({t[22], t[23]});
			@(posedge pclk);
			reg_reads <= '0;
			wait6(A_ST, 32'h0000_0000);
		end
		ev(1'b1, 14'h2000);
		rdc(A_ST, 32'h0000_0000);
		wr(A_EN, 8'h7f);
		ev(1'b0, 14'h2000);
		chk(card_irq, 1'b0);
		rdc(A_ST, 32'h0000_0080);
		int_events <= crirq_pkg::crirq_events_type'(14'h0001);
		wait6(A_ST, 32'h0000_0010);
		rdc(A_ST, 32'h0000_0010);
		int_events <= '0;
		wait6(A_ST, 32'h0000_0000);
		wr(A_EN, 8'h6f);
		wr(A_SEL, 8'h0a);
		@(posedge pclk);
		chk(card_io_bypass_out, 1'b0);
		card_io_in <= 1'b0;
		wait6(A_ST, 32'h0000_0010);
		rdc(A_ST, 32'h0000_0000);
		card_io_in <= 1'b1;
		wr(A_SEL, 8'h0b);
		@(posedge pclk);
		chk(card_io_bypass_out, 1'b1);
		wr(A_SEL, 8'h04);
		ev(1'b1, 14'h2000);
		rdc(A_ST, 32'h0000_0080);
		wr(A_SUP, 8'h01);
		card_detect_input <= 1'b1;
		wait6(A_ST, 32'h0000_0040);
		wr(A_SUP, 8'h00);
		supply_good <= 1'b1;
		wr(A_SUP, 8'hc0);
		chk(supply_select, 2'b11);
		supply_stable_timer <= 1'b1;
		wait6(A_ST, 32'h0000_0020);
		supply_stable_timer <= 1'b0;
		supply_good <= 1'b0;
		wait6(A_ST, 32'h0000_0000);
		chk(deact_seen, 1'b0);
		supply_stable_timer <= 1'b1;
		wait6(A_ST, 32'h0000_0060);
		chk(supply_select, 2'b00);
		chk(deact_seen, 1'b1);
		wr(A_MOD, 8'h10);
		wr(A_SUP, 8'hc0);
		core_supply_fault <= 1'b1;
		wait6(A_SUP, 32'h0000_0020);
		end_sim();
	end
endmodule
